// ==== usb_irq_mask_and_ack.sv ====
// Purpose: Per-source interrupt enable mask, masked status and end-of-interrupt
//          acknowledge for the USB core interrupt sources.
// Assumes: Raw sources arrive from core logic on mclk; registers on a plain port
//          with read data in the cycle after the read strobe.
// Notes:   Interrupt line drops for one cycle after an end-of-interrupt write so
//          an edge-triggered controller sees a fresh edge for remaining sources.
//
// Behaviour
// - Nine core-source enable bits live at bits 24..16 of the mask.
// - Five receive-endpoint enable bits live at bits 12..8 of the mask.
// - Transmit-endpoint enable bits live at bits 4..0 of the mask.
// - Each enable bit passes or blocks its raw source in masked status.
// - Ones written to set register core field set enable bits.
// - Ones written to set register receive or transmit field set enable bits.
// - Ones written to clear register core field clear enable bits.
// - Ones written to clear register endpoint fields clear enable bits.
// - Masked status bits 24..16 give gated core sources, read-only.
// - Masked status gives gated receive bits 12..8, transmit bits 4..0.
// - End-of-interrupt write produces a one-cycle acknowledge strobe.
// - End-of-interrupt write loads the eight-bit acknowledge vector.
// - After end-of-interrupt, interrupt is raised again while sources pend.
// - Masked sources come from the USB core only, not from DMA.
// - Ones written to raw-source clear register pulse source clear outputs.
`timescale 1ns/1ps
module usb_irq_mask_and_ack
    import usb_irq_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic [DATA_W-1:0] core_irq_src,
    output logic      [DATA_W-1:0] src_clear,
    output logic                   cpu_irq,
    output logic                   eoi_write,
    output logic      [VEC_W-1:0]  eoi_vector,
    output logic                   evt_irq
);

    logic [DATA_W-1:0] enable_mask_ff;
    logic [DATA_W-1:0] masked_status;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] src_clear_ff;
    logic [VEC_W-1:0]  eoi_vector_ff;
    logic              eoi_write_ff;
    logic              cpu_irq_ff;
    logic              nxt_cpu_irq;
    logic              evt_irq_ff;
    logic [EVT_W-1:0]  evt_mask_ff;
    logic [EVT_W-1:0]  evt_stat_ff;
    logic [EVT_W-1:0]  evt_set;
    logic [EVT_W-1:0]  evt_clr;
    logic              any_masked;
    logic              mapped;

    logic              wr_set;
    logic              wr_clr;
    logic              wr_eoi;
    logic              wr_rawclr;
    logic              wr_evt_mask;
    logic              rd_evt_stat;

    // Address decode
    assign wr_set      = reg_wr && (reg_addr == OFS_SET);
    assign wr_clr      = reg_wr && (reg_addr == OFS_CLR);
    assign wr_eoi      = reg_wr && (reg_addr == OFS_EOI);
    assign wr_rawclr   = reg_wr && (reg_addr == OFS_RAWCLR);
    assign wr_evt_mask = reg_wr && (reg_addr == OFS_EVT_MASK);
    assign rd_evt_stat = reg_rd && (reg_addr == OFS_EVT_STAT);

    always_comb begin
        case (reg_addr)
            OFS_MASK, OFS_SET, OFS_CLR, OFS_MASKED, OFS_EOI,
            OFS_RAW, OFS_RAWCLR, OFS_EVT_STAT, OFS_EVT_MASK: mapped = 1'b1;
            default:                                         mapped = 1'b0;
        endcase
    end

    // Enable mask: set and clear registers are separate addresses, so a single
    // strobe never carries both; only written ones act on the mask.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_mask_ff <= MASK_RST;
        end else if (wr_set) begin
            enable_mask_ff <= enable_mask_ff | fld(reg_wdata);
        end else if (wr_clr) begin
            enable_mask_ff <= enable_mask_ff & ~fld(reg_wdata);
        end
    end

    // Core-only sources, gated by the enable mask per bit
    assign masked_status = fld(core_irq_src & enable_mask_ff);
    assign any_masked    = |masked_status;

    // End-of-interrupt vector and acknowledge strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eoi_vector_ff <= VEC_RST;
        end else if (wr_eoi) begin
            eoi_vector_ff <= reg_wdata[VEC_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            eoi_write_ff <= 1'b0;
        end else begin
            eoi_write_ff <= wr_eoi;
        end
    end

    // Interrupt line: low for the cycle of the acknowledge strobe, then back
    // up if anything still pends. Costs one cycle of latency on new sources.
    assign nxt_cpu_irq = any_masked && !wr_eoi;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_irq_ff <= 1'b0;
        end else begin
            cpu_irq_ff <= nxt_cpu_irq;
        end
    end

    // Raw-source clear: one-cycle pulse per written one back to the core
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            src_clear_ff <= WORD_ZERO;
        end else if (wr_rawclr) begin
            src_clear_ff <= fld(reg_wdata);
        end else begin
            src_clear_ff <= WORD_ZERO;
        end
    end

    // Block events for the housekeeping interrupt
    always_comb begin
        evt_set           = EVT_RST;
        evt_set[EVT_EOI]  = wr_eoi;
        evt_set[EVT_RISE] = nxt_cpu_irq && !cpu_irq_ff;
        evt_set[EVT_BAD]  = (reg_wr || reg_rd) && !mapped;
        evt_clr           = rd_evt_stat ? {EVT_W{1'b1}} : EVT_RST;
    end

    sticky_flags #(
        .W        (EVT_W)
    ) u_evt_flags (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .set_in   (evt_set),
        .clr_in   (evt_clr),
        .flags_ff (evt_stat_ff)
    );

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_mask_ff <= EVT_RST;
        end else if (wr_evt_mask) begin
            evt_mask_ff <= reg_wdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_irq_ff <= 1'b0;
        end else begin
            evt_irq_ff <= |(evt_stat_ff & evt_mask_ff);
        end
    end

    // Read path; write-only and unmapped words read as zero
    always_comb begin
        rd_mux = WORD_ZERO;
        case (reg_addr)
            OFS_MASK:     rd_mux = enable_mask_ff;
            OFS_MASKED:   rd_mux = masked_status;
            OFS_EOI:      rd_mux = {{(DATA_W-VEC_W){1'b0}}, eoi_vector_ff};
            OFS_RAW:      rd_mux = fld(core_irq_src);
            OFS_EVT_STAT: rd_mux = {{(DATA_W-EVT_W){1'b0}}, evt_stat_ff};
            OFS_EVT_MASK: rd_mux = {{(DATA_W-EVT_W){1'b0}}, evt_mask_ff};
            default:      rd_mux = WORD_ZERO;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_ff <= WORD_ZERO;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= WORD_ZERO;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign src_clear  = src_clear_ff;
    assign cpu_irq    = cpu_irq_ff;
    assign eoi_write  = eoi_write_ff;
    assign eoi_vector = eoi_vector_ff;
    assign evt_irq    = evt_irq_ff;

    // Checks
    default clocking chk_cb @(posedge mclk);
    endclocking

    default disable iff (sys_rst);

    core_set_a: assert property (
        wr_set |=> ((enable_mask_ff & CORE_FIELD & $past(reg_wdata))
                    == (CORE_FIELD & $past(reg_wdata))))
        else $error("core enable bit not set by set write");

    ep_set_a: assert property (
        wr_set |=> ((enable_mask_ff & (RX_FIELD | TX_FIELD) & $past(reg_wdata))
                    == ((RX_FIELD | TX_FIELD) & $past(reg_wdata))))
        else $error("endpoint enable bit not set by set write");

    core_clr_a: assert property (
        wr_clr |=> ((enable_mask_ff & CORE_FIELD & $past(reg_wdata)) == WORD_ZERO))
        else $error("core enable bit not cleared by clear write");

    ep_clr_a: assert property (
        wr_clr |=> ((enable_mask_ff & (RX_FIELD | TX_FIELD) & $past(reg_wdata))
                    == WORD_ZERO))
        else $error("endpoint enable bit not cleared by clear write");

    mask_hold_a: assert property (
        (wr_set || wr_clr) |=>
            (((enable_mask_ff ^ $past(enable_mask_ff)) & ~$past(reg_wdata)) == WORD_ZERO))
        else $error("enable bit changed without a written one");

    mask_layout_a: assert property (
        (enable_mask_ff & ~FIELD_MASK) == WORD_ZERO)
        else $error("enable mask holds bits outside the source fields");

    core_masked_a: assert property (
        (reg_rd && reg_addr == OFS_MASKED) |=>
            ((reg_rdata & CORE_FIELD)
             == ($past(core_irq_src) & $past(enable_mask_ff) & CORE_FIELD)))
        else $error("core masked status read wrong");

    ep_masked_a: assert property (
        (reg_rd && reg_addr == OFS_MASKED) |=>
            ((reg_rdata & ~CORE_FIELD)
             == ($past(core_irq_src) & $past(enable_mask_ff) & (RX_FIELD | TX_FIELD))))
        else $error("endpoint masked status read wrong");

    eoi_strobe_a: assert property (
        wr_eoi |=> eoi_write ##1 (eoi_write == $past(wr_eoi)))
        else $error("acknowledge strobe wrong after end-of-interrupt");

    eoi_vector_a: assert property (
        wr_eoi |=> (eoi_vector == $past(reg_wdata[VEC_W-1:0])))
        else $error("acknowledge vector not loaded");

    rearm_a: assert property (
        wr_eoi |=> !cpu_irq ##1 (cpu_irq == ($past(any_masked) && !$past(wr_eoi))))
        else $error("interrupt not re-raised after end-of-interrupt");

    irq_level_a: assert property (
        (!wr_eoi && any_masked) |=> cpu_irq)
        else $error("interrupt low while masked source pends");

    irq_quiet_a: assert property (
        (enable_mask_ff == WORD_ZERO) [*2] |-> !cpu_irq)
        else $error("interrupt raised with every source masked");

    src_clear_a: assert property (
        wr_rawclr |=> (src_clear == fld($past(reg_wdata))) ##1 (src_clear == WORD_ZERO
                                                               || $past(wr_rawclr)))
        else $error("raw-source clear pulse wrong");

    rdata_once_a: assert property (
        !reg_rd |=> (reg_rdata == WORD_ZERO))
        else $error("read data outside the answer cycle");

    // Quiet side and read-back: strobes, vector and mask move only with their access; gating and read data match
    eoi_quiet_a: assert property (
        !wr_eoi |=> !eoi_write)
        else $error("acknowledge strobe without end-of-interrupt write");

    eoi_hold_a: assert property (
        !wr_eoi |=> $stable(eoi_vector))
        else $error("acknowledge vector changed without a write");

    mask_still_a: assert property (
        !(wr_set || wr_clr) |=> $stable(enable_mask_ff))
        else $error("enable mask changed without a set or clear write");

    gate_block_a: assert property (
        (masked_status & ~(core_irq_src & enable_mask_ff)) == WORD_ZERO)
        else $error("blocked source shows in masked status");

    gate_pass_a: assert property (
        (core_irq_src & enable_mask_ff & FIELD_MASK & ~masked_status) == WORD_ZERO)
        else $error("enabled source missing from masked status");

    irq_drop_a: assert property (
        !any_masked |=> !cpu_irq)
        else $error("interrupt high with no masked source pending");

    masked_rsvd_a: assert property (
        (reg_rd && reg_addr == OFS_MASKED) |=> ((reg_rdata & ~FIELD_MASK) == WORD_ZERO))
        else $error("reserved masked status bits read nonzero");

    raw_read_a: assert property (
        (reg_rd && reg_addr == OFS_RAW) |=> (reg_rdata == ($past(core_irq_src) & FIELD_MASK)))
        else $error("raw source read wrong");

    mask_read_a: assert property (
        (reg_rd && reg_addr == OFS_MASK) |=> (reg_rdata == $past(enable_mask_ff)))
        else $error("enable mask read wrong");

    rawclr_quiet_a: assert property (
        !wr_rawclr |=> (src_clear == WORD_ZERO))
        else $error("raw-source clear pulse without a write");

    evt_read_a: assert property (
        rd_evt_stat |=> (reg_rdata == {{(DATA_W-EVT_W){1'b0}}, $past(evt_stat_ff)}))
        else $error("event status read wrong");

    unmapped_a: assert property (
        (reg_rd && !mapped) |=> (reg_rdata == WORD_ZERO))
        else $error("unmapped address read nonzero");

    eoi_pend_c: cover property (
        any_masked && wr_eoi ##1 !cpu_irq ##1 cpu_irq);

    set_clr_c: cover property (
        wr_set ##[1:4] wr_clr);

    evt_irq_c: cover property (
        evt_irq ##1 rd_evt_stat);

    rawclr_c: cover property (
        wr_rawclr && (reg_wdata & RX_FIELD) != WORD_ZERO);

    irq_rise_c: cover property (
        !cpu_irq ##1 cpu_irq);

endmodule : usb_irq_mask_and_ack

// ==== usb_irq_pkg.sv ====
// Purpose: Shared constants for the USB interrupt mask and acknowledge block.
// Assumes: 32-bit register port, byte addresses, one aligned word per register.
// Notes:   Reserved bits of every field-shaped register read as zero.
package usb_irq_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VEC_W  = 8;
    localparam int EVT_W  = 3;

    // Register map, byte offsets
    localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SET      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CLR      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASKED   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_EOI      = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RAW      = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RAWCLR   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h20;

    // Field layout shared by mask, set, clear, masked and raw registers
    localparam logic [DATA_W-1:0] CORE_FIELD = 32'h01FF_0000;
    localparam logic [DATA_W-1:0] RX_FIELD   = 32'h0000_1F00;
    localparam logic [DATA_W-1:0] TX_FIELD   = 32'h0000_001F;
    localparam logic [DATA_W-1:0] FIELD_MASK = CORE_FIELD | RX_FIELD | TX_FIELD;

    // Reset values
    localparam logic [DATA_W-1:0] MASK_RST     = 32'h0000_0000;
    localparam logic [DATA_W-1:0] WORD_ZERO    = 32'h0000_0000;
    localparam logic [VEC_W-1:0]  VEC_RST      = 8'h00;
    localparam logic [EVT_W-1:0]  EVT_RST      = 3'h0;

    // Event status bit positions
    localparam int EVT_EOI  = 0;
    localparam int EVT_RISE = 1;
    localparam int EVT_BAD  = 2;

    // Keep only the documented source fields of a word
    function automatic logic [DATA_W-1:0] fld(input logic [DATA_W-1:0] w);
        fld = w & FIELD_MASK;
    endfunction : fld

endpackage : usb_irq_pkg

// ==== sticky_flags.sv ====
// Purpose: Sticky event flags, set by hardware and cleared by software.
// Assumes: Set and clear arrive as one-cycle pulses on mclk.
// Notes:   A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ps
module sticky_flags
    import usb_irq_pkg::*;
#(
    parameter int W = EVT_W
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    output logic      [W-1:0] flags_ff
);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_ff <= {W{1'b0}};
        end else begin
            flags_ff <= (flags_ff & ~clr_in) | set_in;
        end
    end

endmodule : sticky_flags

// ==== core_src_model.sv ====
// Purpose: Behavioural USB core raw interrupt sources facing the block.
// Assumes: Raise pulses come from the bench, clear pulses from the block.
// Notes:   Reserved bits stay zero; a raise beats a clear in the same cycle.
`timescale 1ns/1ps
module core_src_model
    import usb_irq_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [DATA_W-1:0] raise,
    input  wire logic [DATA_W-1:0] src_clear,
    output logic      [DATA_W-1:0] src_ff
);
    // Only core-generated sources exist here, no DMA paths
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            src_ff <= WORD_ZERO;
        end else begin
            src_ff <= ((src_ff & ~src_clear) | raise) & FIELD_MASK;
        end
    end
endmodule : core_src_model

// ==== testbench.sv ====
// Purpose: Self-checking bench for the USB interrupt mask and acknowledge block.
// Assumes: Raw sources come from a behavioural core model.
// Notes:   Waits follow the fixed one-cycle latencies of the register port.
`timescale 1ns/1ps
module testbench
    import usb_irq_pkg::*;
;
    logic              mclk      = 1'b0;
    logic              sys_rst   = 1'b1;
    logic [ADDR_W-1:0] reg_addr  = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] raise     = 32'h0000_0000;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] src_clear;
    logic [DATA_W-1:0] src;
    logic              cpu_irq;
    logic              eoi_write;
    logic              evt_irq;
    logic [VEC_W-1:0]  eoi_vector;
    int                error_cnt = 0;
    int                compares  = 0;

    always #2.5 mclk = ~mclk;

    usb_irq_mask_and_ack dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_irq_src(src), .src_clear(src_clear),
        .cpu_irq(cpu_irq), .eoi_write(eoi_write), .eoi_vector(eoi_vector), .evt_irq(evt_irq));
    core_src_model core (.mclk(mclk), .sys_rst(sys_rst), .raise(raise), .src_clear(src_clear), .src_ff(src));

    task automatic chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic acc(input logic w, input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : acc

    // Lowers the strobes at the edge where the last access is taken
    task automatic idle;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : idle

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        acc(1'b1, 1'b0, a, d);
        idle();
        settle(2);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string nm);
        acc(1'b0, 1'b1, a, WORD_ZERO);
        idle();
        settle(0);
        chk(nm, exp, reg_rdata);
        settle(1);
        chk("rdata idle", WORD_ZERO, reg_rdata);
    endtask : rd

    task automatic t_reset;
        chk("cpu_irq", 32'h0, cpu_irq);
        rd(OFS_MASK, MASK_RST, "mask reset");
        rd(OFS_MASKED, WORD_ZERO, "masked reset");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_mask;
        wr(OFS_SET, 32'hFFFF_FFFF);
        rd(OFS_MASK, FIELD_MASK, "mask all");
        wr(OFS_CLR, 32'h0100_1001);
        rd(OFS_MASK, 32'h00FF_0F1E, "mask clear");
        wr(OFS_SET, WORD_ZERO);
        wr(OFS_CLR, WORD_ZERO);
        wr(OFS_MASK, WORD_ZERO);
        rd(OFS_MASK, 32'h00FF_0F1E, "mask zero write");
        wr(OFS_SET, 32'hFF00_F0E1);
        rd(OFS_MASK, FIELD_MASK, "mask set");
        $display("t_mask done");
    endtask : t_mask

    task automatic t_masked;
        @(posedge mclk);
        raise <= 32'hFFFF_FFFF;
        @(posedge mclk);
        raise <= WORD_ZERO;
        wr(OFS_CLR, 32'h0155_0A05);
        rd(OFS_MASKED, 32'h00AA_151A, "masked");
        wr(OFS_MASKED, 32'hFFFF_FFFF);
        rd(OFS_MASKED, 32'h00AA_151A, "masked ro");
        rd(OFS_RAW, FIELD_MASK, "raw");
        chk("cpu_irq", 32'h1, cpu_irq);
        $display("t_masked done");
    endtask : t_masked

    task automatic t_eoi;
        acc(1'b1, 1'b0, OFS_EOI, 32'h0000_00A5);
        idle();
        settle(0);
        chk("eoi_write", 32'h1, eoi_write);
        chk("eoi_vector", 32'hA5, eoi_vector);
        chk("cpu_irq eoi", 32'h0, cpu_irq);
        settle(1);
        chk("eoi_write end", 32'h0, eoi_write);
        chk("cpu_irq again", 32'h1, cpu_irq);
        rd(OFS_EOI, 32'h0000_00A5, "eoi read");
        acc(1'b1, 1'b0, OFS_EOI, WORD_ZERO);
        acc(1'b1, 1'b0, OFS_EOI, WORD_ZERO);
        idle();
        settle(0);
        chk("eoi_write b2b", 32'h1, eoi_write);
        chk("cpu_irq b2b", 32'h0, cpu_irq);
        chk("eoi_vector zero", 32'h0, eoi_vector);
        settle(1);
        chk("cpu_irq b2b again", 32'h1, cpu_irq);
        $display("t_eoi done");
    endtask : t_eoi

    task automatic t_rawclr;
        wr(OFS_SET, FIELD_MASK);
        acc(1'b1, 1'b0, OFS_RAWCLR, 32'hFFFF_E0FF);
        idle();
        settle(0);
        chk("src_clear", 32'h01FF_001F, src_clear);
        settle(1);
        chk("src_clear end", WORD_ZERO, src_clear);
        rd(OFS_MASKED, 32'h0000_1F00, "masked rx left");
        chk("cpu_irq rx", 32'h1, cpu_irq);
        wr(OFS_RAWCLR, FIELD_MASK);
        rd(OFS_RAW, WORD_ZERO, "raw cleared");
        chk("cpu_irq idle", 32'h0, cpu_irq);
        $display("t_rawclr done");
    endtask : t_rawclr

    task automatic t_events;
        rd(8'h40, WORD_ZERO, "unmapped");
        chk("evt_irq masked", 32'h0, evt_irq);
        wr(OFS_EVT_MASK, 32'h0000_0007);
        chk("evt_irq", 32'h1, evt_irq);
        rd(OFS_EVT_STAT, 32'h0000_0007, "evt stat");
        rd(OFS_EVT_STAT, WORD_ZERO, "evt cleared");
        chk("evt_irq cleared", 32'h0, evt_irq);
        $display("t_events done");
    endtask : t_events

    task automatic tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Guards against a hang anywhere in the sequence
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("MISMATCH run length expected done seen timeout");
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        settle(1);
        t_reset();
        t_mask();
        t_masked();
        t_eoi();
        t_rawclr();
        t_events();
        tally_and_finish();
    end
endmodule : testbench
